// ===== common/psmc_consts.svh
// Offsets, field positions, reset values and timing counts of the power-save controller
`ifndef PSMC_CONSTS_SVH
`define PSMC_CONSTS_SVH
`define PSMC_OFF_CTL       12'h000
`define PSMC_OFF_PROT      12'h004
`define PSMC_OFF_STAT      12'h008
`define PSMC_PROT_KEY      8'ha5
`define PSMC_CTL_RST       8'h00
`define PSMC_BIT_EXTCK     0
`define PSMC_BIT_DCLK_LO   1
`define PSMC_BIT_TBCS      3
`define PSMC_BIT_STOP      4
`define PSMC_BIT_IDLE      5
`define PSMC_BIT_DCLK_HI   6
`define PSMC_PREFETCH_DEPTH 3'h4
`define PSMC_STAB_SHORT    20'h00100
`define PSMC_STAB_LONG     20'h00200
`endif

// ===== common/psmc_pkg.sv
// Types shared by the power-save controller
package psmc_pkg;
  typedef enum logic [2:0] {
    PSMC_RUN, PSMC_HALT_FILL, PSMC_HALT, PSMC_IDLE, PSMC_STOP, PSMC_STAB, PSMC_RESUME
  } psmc_state_t;

  typedef struct packed {
    logic data_oe;
    logic addr_oe;
    logic rd_strobe_oe;
    logic wr_strobe_force_hi;
    logic hold_ack_oe;
    logic hold_wait_sample;
  } psmc_bus_ctl_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_pll_en;
    logic ck_out_oe;
    logic ck_out_force_lo;
  } psmc_clk_ctl_t;
endpackage

// ===== hdl/psmc_power_save.sv
// Power-save mode controller: halt, idle, software stop and clock-output inhibit
`include "psmc_consts.svh"
module psmc_power_save (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   halt_instr,
  input  wire logic                   prefetch_full,
  input  wire logic                   nmi_pin,
  input  wire logic                   maskable_req,
  input  wire logic                   maskable_higher,
  input  wire logic                   in_nmi_routine,
  input  wire logic                   interrupts_enabled_state,
  input  wire logic                   clock_mode_select_pin,
  output logic                        nmi_ack,
  output logic                        maskable_ack,
  output logic                        nmi_pending,
  output logic                        cpu_resume,
  output psmc_pkg::psmc_clk_ctl_t     clk_ctl,
  output psmc_pkg::psmc_bus_ctl_t     bus_ctl
);
  import psmc_pkg::*;

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  logic [7:0]  power_save_control_reg_ff;
  logic        prot_armed_ff;
  psmc_state_t state_ff;
  psmc_state_t nxt_state;
  logic [19:0] stab_cnt_ff;
  logic        nmi_dly_ff;
  logic        prot_err_ff;

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  wire acc      = psel && penable;
  wire wr_ctl   = acc && pwrite && is_addr(paddr, `PSMC_OFF_CTL);
  wire wr_prot  = acc && pwrite && is_addr(paddr, `PSMC_OFF_PROT);
  wire mapped   = is_addr(paddr, `PSMC_OFF_CTL) || is_addr(paddr, `PSMC_OFF_PROT)
                || is_addr(paddr, `PSMC_OFF_STAT);
  wire nmi_edge = nmi_pin && !nmi_dly_ff;
  wire ext_clk  = power_save_control_reg_ff[`PSMC_BIT_EXTCK];

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  always_comb begin
    prdata = 32'h0000_0000;
    if (is_addr(paddr, `PSMC_OFF_CTL)) begin
      prdata[7:0] = power_save_control_reg_ff;
    end else if (is_addr(paddr, `PSMC_OFF_STAT)) begin
      prdata[3:0] = {prot_err_ff, state_ff};
    end
  end

  // Key write arms exactly the next bus write; any other write disarms it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_armed_ff <= 1'b0;
      prot_err_ff   <= 1'b0;
    end else if (acc && pwrite) begin
      prot_armed_ff <= wr_prot && pwdata[7:0] == `PSMC_PROT_KEY;
      if (wr_ctl && !prot_armed_ff) begin
        prot_err_ff <= 1'b1;
      end else if (wr_prot) begin
        prot_err_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_save_control_reg_ff <= `PSMC_CTL_RST;
    end else if (wr_ctl && prot_armed_ff && state_ff == PSMC_RUN) begin
      power_save_control_reg_ff <= pwdata[7:0];
    end else if (state_ff == PSMC_STOP && nmi_edge) begin
      power_save_control_reg_ff[`PSMC_BIT_STOP] <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Mode sequencer
  // ------------------------------------------------------------
  wire ctl_stop = power_save_control_reg_ff[`PSMC_BIT_STOP];
  wire ctl_idle = power_save_control_reg_ff[`PSMC_BIT_IDLE];
  // Mode request acts the cycle after the accepted write lands
  logic mode_req_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_req_ff <= 1'b0;
    end else begin
      mode_req_ff <= wr_ctl && prot_armed_ff && state_ff == PSMC_RUN
                     && (pwdata[`PSMC_BIT_STOP] || pwdata[`PSMC_BIT_IDLE]);
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PSMC_RUN: begin
        if (mode_req_ff && ctl_stop) begin
          nxt_state = PSMC_STOP;
        end else if (mode_req_ff && ctl_idle) begin
          nxt_state = PSMC_IDLE;
        end else if (halt_instr) begin
          nxt_state = PSMC_HALT_FILL;
        end
      end
      PSMC_HALT_FILL: begin
        if (prefetch_full) begin
          nxt_state = PSMC_HALT;
        end
      end
      PSMC_HALT: begin
        if (nmi_edge || maskable_req) begin
          nxt_state = PSMC_RESUME;
        end
      end
      PSMC_IDLE: begin
        if (nmi_edge) begin
          nxt_state = PSMC_RESUME;
        end
      end
      PSMC_STOP: begin
        if (nmi_edge) begin
          // Resonator in PLL mode needs the oscillator to settle first
          nxt_state = (!clock_mode_select_pin && !ext_clk) ? PSMC_STAB : PSMC_RESUME;
        end
      end
      PSMC_STAB: begin
        if (stab_cnt_ff == 20'h00000) begin
          nxt_state = PSMC_RESUME;
        end
      end
      PSMC_RESUME: nxt_state = PSMC_RUN;
      default:     nxt_state = PSMC_RUN;
    endcase
  end

  // Reset pin is presetn itself, so every mode leaves exactly as a system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= PSMC_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_dly_ff <= 1'b0;
    end else begin
      nmi_dly_ff <= nmi_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_cnt_ff <= 20'h00000;
    end else if (state_ff == PSMC_STOP) begin
      stab_cnt_ff <= power_save_control_reg_ff[`PSMC_BIT_TBCS] ? `PSMC_STAB_LONG
                                                             : `PSMC_STAB_SHORT;
    end else if (state_ff == PSMC_STAB && stab_cnt_ff != 20'h00000) begin
      stab_cnt_ff <= stab_cnt_ff - 20'h00001;
    end
  end

  // ------------------------------------------------------------
  // Release source and interrupt outcome
  // ------------------------------------------------------------
  logic src_nmi_ff;
  logic src_mask_ff;
  logic was_deep_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_nmi_ff  <= 1'b0;
      src_mask_ff <= 1'b0;
      was_deep_ff <= 1'b0;
    end else if (nxt_state != state_ff && (state_ff == PSMC_HALT
                 || state_ff == PSMC_IDLE || state_ff == PSMC_STOP)) begin
      src_nmi_ff  <= nmi_edge;
      src_mask_ff <= !nmi_edge && maskable_req;
      was_deep_ff <= state_ff != PSMC_HALT;
    end
  end

  // Acknowledge decisions are one-cycle pulses in the cycle after the resume step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_ack      <= 1'b0;
      maskable_ack <= 1'b0;
      nmi_pending  <= 1'b0;
      cpu_resume   <= 1'b0;
    end else begin
      cpu_resume   <= state_ff == PSMC_RESUME;
      nmi_ack      <= state_ff == PSMC_RESUME && src_nmi_ff
                      && !(was_deep_ff && in_nmi_routine);
      nmi_pending  <= state_ff == PSMC_RESUME && src_nmi_ff
                      && was_deep_ff && in_nmi_routine;
      maskable_ack <= state_ff == PSMC_RESUME && src_mask_ff && maskable_higher
                      && interrupts_enabled_state;
    end
  end

  // ------------------------------------------------------------
  // Clock gates and pin states
  // ------------------------------------------------------------
  wire deep    = state_ff == PSMC_IDLE || state_ff == PSMC_STOP || state_ff == PSMC_STAB;
  wire inhibit = power_save_control_reg_ff[`PSMC_BIT_DCLK_LO]
              && power_save_control_reg_ff[`PSMC_BIT_DCLK_HI];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_ctl <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, osc_pll_en: 1'b1,
                   ck_out_oe: 1'b1, ck_out_force_lo: 1'b0};
      bus_ctl <= '{data_oe: 1'b1, addr_oe: 1'b1, rd_strobe_oe: 1'b1,
                   wr_strobe_force_hi: 1'b0, hold_ack_oe: 1'b1, hold_wait_sample: 1'b1};
    end else begin
      clk_ctl.cpu_clk_en      <= nxt_state == PSMC_RUN || nxt_state == PSMC_HALT_FILL;
      clk_ctl.periph_clk_en   <= !(nxt_state == PSMC_IDLE || nxt_state == PSMC_STOP
                                   || nxt_state == PSMC_STAB);
      clk_ctl.osc_pll_en      <= nxt_state != PSMC_STOP;
      clk_ctl.ck_out_oe       <= !inhibit;
      clk_ctl.ck_out_force_lo <= deep;
      bus_ctl.data_oe            <= !deep;
      bus_ctl.addr_oe            <= !deep;
      bus_ctl.rd_strobe_oe       <= !deep;
      bus_ctl.wr_strobe_force_hi <= deep;
      bus_ctl.hold_ack_oe        <= !deep;
      bus_ctl.hold_wait_sample   <= !deep;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_halt_no_write;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == PSMC_RUN && !halt_instr && !mode_req_ff) |=> state_ff == PSMC_RUN;
  endproperty
  a_halt_no_write: assert property (p_halt_no_write) else $error("run left without cause");

  property p_fill;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == PSMC_HALT_FILL && !prefetch_full) |=> state_ff == PSMC_HALT_FILL;
  endproperty
  a_fill: assert property (p_fill) else $error("halt before queue full");

  // Release always passes one resume step before the CPU is let go
  sequence s_resume;
    state_ff == PSMC_RESUME ##1 cpu_resume;
  endsequence

  property p_halt_release;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == PSMC_HALT && maskable_req) |=> s_resume;
  endproperty
  a_halt_release: assert property (p_halt_release) else $error("halt not released");

  property p_idle_hold;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == PSMC_IDLE && !nmi_edge) |=> state_ff == PSMC_IDLE;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle left without nmi");

  sequence s_stop_entered;
    state_ff == PSMC_STOP ##1 !clk_ctl.osc_pll_en;
  endsequence

  property p_stop_pref;
    @(posedge pclk) disable iff (!presetn)
      (mode_req_ff && ctl_stop && state_ff == PSMC_RUN) |=> s_stop_entered;
  endproperty
  a_stop_pref: assert property (p_stop_pref) else $error("stop not selected");

  property p_stop_clear;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == PSMC_STOP && nmi_edge) |=> !power_save_control_reg_ff[`PSMC_BIT_STOP];
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("stop bit kept");

  property p_protect;
    @(posedge pclk) disable iff (!presetn)
      (wr_ctl && !prot_armed_ff) |=> $stable(power_save_control_reg_ff);
  endproperty
  a_protect: assert property (p_protect) else $error("unprotected write took effect");

  property p_inhibit;
    @(posedge pclk) disable iff (!presetn)
      inhibit |=> !clk_ctl.ck_out_oe;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("clock out not inhibited");

  property p_deep_pins;
    @(posedge pclk) disable iff (!presetn)
      deep |-> ##1 (!bus_ctl.data_oe && bus_ctl.wr_strobe_force_hi) or ##1 !deep;
  endproperty
  a_deep_pins: assert property (p_deep_pins) else $error("bus not parked");

  property p_halt_clocks;
    @(posedge pclk) disable iff (!presetn)
      state_ff == PSMC_HALT |-> !clk_ctl.cpu_clk_en && clk_ctl.periph_clk_en
                                && clk_ctl.osc_pll_en;
  endproperty
  a_halt_clocks: assert property (p_halt_clocks) else $error("halt clocks wrong");

  // A resonator restart must pass through the settle count, never straight to resume
  property p_stab_entry;
    @(posedge pclk) disable iff (!presetn)
      (state_ff == PSMC_STOP && nmi_edge && !clock_mode_select_pin && !ext_clk)
        |=> state_ff == PSMC_STAB && !cpu_resume;
  endproperty
  a_stab_entry: assert property (p_stab_entry) else $error("no oscillator wait");

  property p_resume_clock;
    @(posedge pclk) disable iff (!presetn)
      cpu_resume |-> clk_ctl.cpu_clk_en && clk_ctl.periph_clk_en;
  endproperty
  a_resume_clock: assert property (p_resume_clock) else $error("resumed with clock gated");
endmodule // psmc_power_save

// ===== bench/psmc_cpu_model.sv
// CPU core model: issues the halt instruction and refills its prefetch queue
module psmc_cpu_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       do_halt,
  input  wire logic [3:0] fill_cycles,
  output logic            halt_instr,
  output logic            prefetch_full
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] fill_ff;

  // --------------------------------------------------
  // Instruction stream
  // --------------------------------------------------
  // Halt comes only from the instruction stream, never from a register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) halt_instr <= 1'b0;
    else halt_instr <= do_halt;
  end

  // Queue empties at the halt and refills at the pace the bench picks,
  // so both a prompt and a slow fill can be exercised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_ff       <= 4'h0;
      prefetch_full <= 1'b0;
    end else if (halt_instr) begin
      fill_ff       <= fill_cycles;
      prefetch_full <= 1'b0;
    end else if (fill_ff != 4'h0) begin
      fill_ff <= fill_ff - 4'h1;
    end else begin
      prefetch_full <= 1'b1;
    end
  end
endmodule // psmc_cpu_model

// ===== bench/psmc_power_save_test.sv
// Self-checking bench for the power-save controller
`include "psmc_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module psmc_power_save_test;
  timeunit 1ns;
  timeprecision 1ps;
  import psmc_pkg::*;
  logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0, prdata, rd;
  logic          pready, pslverr, serr, halt_instr, prefetch_full, do_halt = 1'b0;
  logic [3:0]    fill = 4'h1;
  logic          nmi_pin = 1'b0, maskable_req = 1'b0, maskable_higher = 1'b1;
  logic          in_nmi_routine = 1'b0, interrupts_enabled_state = 1'b1;
  logic          clock_mode_select_pin = 1'b0;
  logic          nmi_ack, maskable_ack, nmi_pending, cpu_resume;
  logic [2:0]    seen;
  psmc_clk_ctl_t clk_ctl;
  psmc_bus_ctl_t bus_ctl;
  int            checks = 0, n_mismatch = 0, cycles = 0, n_wait, stab;

  psmc_power_save u_psmc_power_save (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_instr(halt_instr),
    .prefetch_full(prefetch_full), .nmi_pin(nmi_pin), .maskable_req(maskable_req),
    .maskable_higher(maskable_higher), .in_nmi_routine(in_nmi_routine),
    .interrupts_enabled_state(interrupts_enabled_state),
    .clock_mode_select_pin(clock_mode_select_pin), .nmi_ack(nmi_ack),
    .maskable_ack(maskable_ack), .nmi_pending(nmi_pending), .cpu_resume(cpu_resume),
    .clk_ctl(clk_ctl), .bus_ctl(bus_ctl));
  psmc_cpu_model u_psmc_cpu_model (.pclk(pclk), .presetn(presetn), .do_halt(do_halt),
    .fill_cycles(fill), .halt_instr(halt_instr), .prefetch_full(prefetch_full));

  always #2 pclk = ~pclk;

  // --------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ctl_wr(input logic [7:0] v);
    apb(1'b1, `PSMC_OFF_PROT, {24'h0, `PSMC_PROT_KEY});
    apb(1'b1, `PSMC_OFF_CTL, {24'h0, v});
    repeat (5) @(posedge pclk);
  endtask

  task automatic chk_state(input psmc_state_t st);
    apb(1'b0, `PSMC_OFF_STAT, 32'h0);
    `CHK(rd[2:0], st)
  endtask

  task automatic chk_reset();
    apb(1'b0, `PSMC_OFF_CTL, 32'h0);
    `CHK(rd, 32'h0)
    chk_state(PSMC_RUN);
    `CHK(clk_ctl, 5'h1e)
    `CHK(bus_ctl, 6'h3b)
  endtask

  // Pulses are collected over the whole wait; the NMI pin is let go early
  // so a release that counts from the inactive edge still completes
  task automatic wait_resume();
    seen = 3'h0;
    n_wait = 0;
    do begin
      @(posedge pclk);
      n_wait++;
      seen |= {nmi_ack, nmi_pending, maskable_ack};
      if (n_wait == 2) nmi_pin <= 1'b0;
    end while (cpu_resume !== 1'b1 && n_wait < 2000);
    @(posedge pclk);
    seen |= {nmi_ack, nmi_pending, maskable_ack};
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // --------------------------------------------------
  // Scenarios
  // --------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk_reset();
    apb(1'b1, `PSMC_OFF_CTL, 32'h20);
    chk_state(PSMC_RUN);
    `CHK(rd[3], 1'b1)
    apb(1'b1, `PSMC_OFF_PROT, {24'h0, `PSMC_PROT_KEY});
    apb(1'b1, `PSMC_OFF_PROT, 32'h0);
    apb(1'b1, `PSMC_OFF_CTL, 32'h20);
    chk_state(PSMC_RUN);
    apb(1'b0, 12'h00c, 32'h0);
    `CHK(serr, 1'b1)
    ctl_wr(8'h42);
    `CHK(clk_ctl, 5'h1c)
    chk_state(PSMC_RUN);
    ctl_wr(8'h00);
    for (int i = 0; i < 4; i++) begin
      do_halt                  <= 1'b1;
      maskable_higher          <= (i != 0);
      interrupts_enabled_state <= (i != 2);
      fill                     <= (i == 0) ? 4'hc : 4'h1;
      @(posedge pclk);
      do_halt <= 1'b0;
      if (i == 0) begin
        repeat (2) @(posedge pclk);
        chk_state(PSMC_HALT_FILL);
        `CHK(clk_ctl.cpu_clk_en, 1'b1)
      end
      repeat (16) @(posedge pclk);
      chk_state(PSMC_HALT);
      `CHK(clk_ctl, 5'h0e)
      `CHK(bus_ctl, 6'h3b)
      if (i == 3) nmi_pin <= 1'b1;
      else maskable_req <= 1'b1;
      wait_resume();
      maskable_req <= 1'b0;
      `CHK(seen, (i == 3) ? 3'h4 : {2'h0, i == 1})
      `CHK(n_wait < 20, 1'b1)
      repeat (3) @(posedge pclk);
      `CHK(clk_ctl, 5'h1e)
    end
    for (int r = 0; r < 2; r++) begin
      in_nmi_routine <= r[0];
      ctl_wr(r[0] ? 8'h62 : 8'h20);
      chk_state(PSMC_IDLE);
      `CHK(clk_ctl[4:1], {3'h1, ~r[0]})
      if (r == 0) `CHK(clk_ctl.ck_out_force_lo, 1'b1)
      `CHK(bus_ctl, 6'h04)
      maskable_req <= 1'b1;
      repeat (20) @(posedge pclk);
      maskable_req <= 1'b0;
      chk_state(PSMC_IDLE);
      nmi_pin <= 1'b1;
      wait_resume();
      `CHK(seen, r[0] ? 3'h2 : 3'h4)
    end
    for (int t = 0; t < 2; t++) begin
      in_nmi_routine <= t[0];
      ctl_wr(t[0] ? 8'h38 : 8'h10);
      chk_state(PSMC_STOP);
      `CHK(clk_ctl, 5'h03)
      nmi_pin <= 1'b1;
      wait_resume();
      stab = t[0] ? `PSMC_STAB_LONG : `PSMC_STAB_SHORT;
      `CHK((n_wait >= stab) && (n_wait < stab + 20), 1'b1)
      `CHK(seen, t[0] ? 3'h2 : 3'h4)
      apb(1'b0, `PSMC_OFF_CTL, 32'h0);
      `CHK(rd[4], 1'b0)
    end
    in_nmi_routine <= 1'b0;
    ctl_wr(8'h20);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk_reset();
    give_verdict();
  end
endmodule // psmc_power_save_test
